/* File: hdl/lscirq_pkg.sv */
package lscirq_pkg;
    // Register map on the plain register port
    localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h0f04;
    localparam logic [15:0] ADDR_STATUS = 16'h0f05;
    localparam logic [15:0] ADDR_CHANGE_STATUS = 16'h0f06;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h0f08;

    // Bit positions shared by status, change, enable and mask
    localparam int QRSS_BIT = 0;
    localparam int FIFO_LIMIT_BIT = 5;
    localparam int DRIVE_MON_BIT = 6;
    localparam int RSVD_BIT = 7;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CHANGE_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Number of watched status lines
    localparam int WATCH_COUNT = 3;

    // Register port decode result
    typedef enum {
        LSC_SEL_NONE,
        LSC_SEL_ENABLE,
        LSC_SEL_STATUS,
        LSC_SEL_CHANGE,
        LSC_SEL_MASK
    } lsc_sel_t;
endpackage

/* File: hdl/lsc_watch_if.sv */
`timescale 1ns/1ps
// Status line handed to a change detector and its sticky flag back
interface lsc_watch_if;
    logic level;
    logic clearReq;
    logic flag;
    modport watcher (input level, input clearReq, output flag);
    modport owner (output level, output clearReq, input flag);
endinterface

/* File: hdl/lsc_change_flag.sv */
`timescale 1ns/1ps
module lsc_change_flag
    import lscirq_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    lsc_watch_if.watcher watch
);
    logic prev_ff;
    logic flag_ff;
    logic nxt_flag;
    logic changed;

    // Last seen level, starts at the status reset value
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prev_ff <= STATUS_RESET[0];
        end else begin
            prev_ff <= watch.level;
        end
    end

    assign changed = watch.level ^ prev_ff;

    // Set beats clear so a change during a read is not lost
    always_comb begin
        nxt_flag = flag_ff;
        if (watch.clearReq) begin
            nxt_flag = 1'b0;
        end
        if (changed) begin
            nxt_flag = 1'b1; // RULE10
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flag_ff <= CHANGE_RESET[0];
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign watch.flag = flag_ff;

    AST_CHANGE_SETS: assert property (@(posedge mclk) disable iff (!reset_n)
        changed |=> flag_ff) // RULE10
        else $error("change did not set flag");
endmodule

/* File: hdl/lsc_irq_top.sv */
`timescale 1ns/1ps
// Functional notes
// [RULE1] Status bit 0 reads the live QRSS lock level, reset value 0.
// [RULE2] With the QRSS enable set, each QRSS lock edge raises the interrupt; the code also needs the QRSS mask bit set.
// [RULE3] Software puts line interface and framer in single-rail first.
// [RULE4] Change bit 6 sets whenever the drive-monitor status changed.
// [RULE5] Change bit 5 sets whenever the FIFO-limit status changed.
// [RULE6] Change bits clear on read, reset to 0, read 0 with no change.
// [RULE7] Change bit 7 is reserved and always reads 0.
// [RULE8] Software reads the status register for present conditions.
// [RULE9] Change bit 0 sets whenever the QRSS lock status changed.
// [RULE10] A change in the same cycle as the clearing read keeps the flag.
module lsc_irq_top
    import lscirq_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic qrssLockIn,
    input wire logic driveMonitorIn,
    input wire logic fifoLimitIn,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic irq
);
    logic [7:0] status_ff;
    logic [7:0] enable_ff;
    logic [7:0] mask_ff;
    logic [7:0] regRdata_ff;
    logic irq_ff;
    logic [7:0] changeFlags;
    logic [7:0] nxt_rdata;
    logic nxt_irq;
    logic changeRead;
    lsc_sel_t sel;

    lsc_watch_if watchQrss();
    lsc_watch_if watchFifo();
    lsc_watch_if watchDrive();

    // Address decode; unmapped reads return zero
    always_comb begin
        case (regAddr)
            ADDR_IRQ_ENABLE: sel = LSC_SEL_ENABLE;
            ADDR_STATUS: sel = LSC_SEL_STATUS;
            ADDR_CHANGE_STATUS: sel = LSC_SEL_CHANGE;
            ADDR_IRQ_MASK: sel = LSC_SEL_MASK;
            default: sel = LSC_SEL_NONE;
        endcase
    end

    assign changeRead = regRd && (sel == LSC_SEL_CHANGE);

    // Registered copy of the live status lines
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= STATUS_RESET;
        end else begin
            status_ff <= READ_ZERO;
            status_ff[QRSS_BIT] <= qrssLockIn; // RULE1
            status_ff[FIFO_LIMIT_BIT] <= fifoLimitIn;
            status_ff[DRIVE_MON_BIT] <= driveMonitorIn;
        end
    end

    // Detectors watch the registered status, so flags match reads
    assign watchQrss.level = status_ff[QRSS_BIT];
    assign watchFifo.level = status_ff[FIFO_LIMIT_BIT];
    assign watchDrive.level = status_ff[DRIVE_MON_BIT];
    assign watchQrss.clearReq = changeRead; // RULE6
    assign watchFifo.clearReq = changeRead;
    assign watchDrive.clearReq = changeRead;

    lsc_change_flag uQrss (
        .mclk(mclk),
        .reset_n(reset_n),
        .watch(watchQrss.watcher)
    ); // RULE9
    lsc_change_flag uFifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .watch(watchFifo.watcher)
    ); // RULE5
    lsc_change_flag uDrive (
        .mclk(mclk),
        .reset_n(reset_n),
        .watch(watchDrive.watcher)
    ); // RULE4

    // Assemble change register; reserved bits stay zero
    always_comb begin
        changeFlags = READ_ZERO;
        changeFlags[QRSS_BIT] = watchQrss.flag;
        changeFlags[FIFO_LIMIT_BIT] = watchFifo.flag;
        changeFlags[DRIVE_MON_BIT] = watchDrive.flag;
        changeFlags[RSVD_BIT] = 1'b0; // RULE7
    end

    // Enable register, only bits with a source are kept
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            enable_ff <= ENABLE_RESET;
        end else if (regWr && sel == LSC_SEL_ENABLE) begin
            enable_ff <= READ_ZERO;
            enable_ff[QRSS_BIT] <= regWdata[QRSS_BIT];
            enable_ff[FIFO_LIMIT_BIT] <= regWdata[FIFO_LIMIT_BIT];
            enable_ff[DRIVE_MON_BIT] <= regWdata[DRIVE_MON_BIT];
        end
    end

    // Mask register, same layout, 1 lets a flag through
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_ff <= MASK_RESET;
        end else if (regWr && sel == LSC_SEL_MASK) begin
            mask_ff <= READ_ZERO;
            mask_ff[QRSS_BIT] <= regWdata[QRSS_BIT];
            mask_ff[FIFO_LIMIT_BIT] <= regWdata[FIFO_LIMIT_BIT];
            mask_ff[DRIVE_MON_BIT] <= regWdata[DRIVE_MON_BIT];
        end
    end

    // Read mux, data valid the cycle after the strobe only
    always_comb begin
        nxt_rdata = READ_ZERO;
        if (regRd) begin
            case (sel)
                LSC_SEL_ENABLE: nxt_rdata = enable_ff;
                LSC_SEL_STATUS: nxt_rdata = status_ff; // RULE1
                LSC_SEL_CHANGE: nxt_rdata = changeFlags; // RULE6
                LSC_SEL_MASK: nxt_rdata = mask_ff;
                default: nxt_rdata = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata_ff <= READ_ZERO;
        end else begin
            regRdata_ff <= nxt_rdata;
        end
    end

    // Interrupt needs both enable and mask; level until flag read
    assign nxt_irq = |(changeFlags & enable_ff & mask_ff); // RULE2

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign regRdata = regRdata_ff;
    assign irq = irq_ff;

    AST_STATUS_FOLLOWS: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_STATUS
        |=> regRdata[QRSS_BIT] == $past(status_ff[QRSS_BIT])) // RULE1
        else $error("status read lost lock bit");

    AST_QRSS_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
        $changed(status_ff[QRSS_BIT]) && enable_ff[QRSS_BIT]
        && mask_ff[QRSS_BIT] && $stable(enable_ff) && $stable(mask_ff)
        |=> ##1 irq) // RULE2
        else $error("lock edge gave no interrupt");

    AST_DRIVE_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
        $changed(status_ff[DRIVE_MON_BIT])
        |=> changeFlags[DRIVE_MON_BIT]) // RULE4
        else $error("drive monitor change missed");

    AST_FIFO_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
        $changed(status_ff[FIFO_LIMIT_BIT])
        |=> changeFlags[FIFO_LIMIT_BIT]) // RULE5
        else $error("fifo limit change missed");

    AST_CLEAR_ON_READ: assert property (@(posedge mclk) disable iff (!reset_n)
        changeRead && $stable(status_ff) |=> changeFlags == READ_ZERO) // RULE6
        else $error("change flags not cleared by read");

    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_CHANGE |=> !regRdata[RSVD_BIT]) // RULE7
        else $error("reserved bit read as one");

    AST_QRSS_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
        $changed(status_ff[QRSS_BIT]) |=> changeFlags[QRSS_BIT]) // RULE9
        else $error("lock change missed");

    AST_SET_WINS: assert property (@(posedge mclk) disable iff (!reset_n)
        changeRead && $changed(status_ff[QRSS_BIT])
        |=> regRdata[QRSS_BIT] == $past(changeFlags[QRSS_BIT])
        && changeFlags[QRSS_BIT]) // RULE10
        else $error("change lost during clearing read");

    AST_NO_FLAG_NO_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
        changeFlags == READ_ZERO |=> !irq) // RULE2
        else $error("interrupt without flag");

    // Status copy tracks each live line one edge late
    AST_QRSS_TRACK: assert property (@(posedge mclk) disable iff (!reset_n)
        1'b1 |=> status_ff[QRSS_BIT] == $past(qrssLockIn)) // RULE1
        else $error("lock status not tracking input");

    AST_FIFO_TRACK: assert property (@(posedge mclk) disable iff (!reset_n)
        1'b1 |=> status_ff[FIFO_LIMIT_BIT] == $past(fifoLimitIn)) // RULE5
        else $error("fifo status not tracking input");

    AST_DRIVE_TRACK: assert property (@(posedge mclk) disable iff (!reset_n)
        1'b1 |=> status_ff[DRIVE_MON_BIT] == $past(driveMonitorIn)) // RULE4
        else $error("drive status not tracking input");

    // Status reads carry every live bit, reserved bits low
    AST_STAT_FIFO_RD: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_STATUS
        |=> regRdata[FIFO_LIMIT_BIT] == $past(status_ff[FIFO_LIMIT_BIT]))
        else $error("status read lost fifo bit"); // RULE5

    AST_STAT_DRV_RD: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_STATUS
        |=> regRdata[DRIVE_MON_BIT] == $past(status_ff[DRIVE_MON_BIT]))
        else $error("status read lost drive bit"); // RULE4

    AST_STAT_RSVD: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_STATUS |=> !regRdata[RSVD_BIT]) // RULE1
        else $error("status reserved bit read as one");

    // Change reads return the flags as they stood at the strobe
    AST_CHG_QRSS_RD: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_CHANGE
        |=> regRdata[QRSS_BIT] == $past(changeFlags[QRSS_BIT])) // RULE9
        else $error("change read lost lock flag");

    AST_CHG_FIFO_RD: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_CHANGE
        |=> regRdata[FIFO_LIMIT_BIT] == $past(changeFlags[FIFO_LIMIT_BIT]))
        else $error("change read lost fifo flag"); // RULE5

    AST_CHG_DRV_RD: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_CHANGE
        |=> regRdata[DRIVE_MON_BIT] == $past(changeFlags[DRIVE_MON_BIT]))
        else $error("change read lost drive flag"); // RULE4

    // Flags are sticky until the clearing read
    AST_QRSS_STICKY: assert property (@(posedge mclk) disable iff (!reset_n)
        !changeRead && changeFlags[QRSS_BIT] |=> changeFlags[QRSS_BIT])
        else $error("lock flag dropped without read"); // RULE9

    AST_FIFO_STICKY: assert property (@(posedge mclk) disable iff (!reset_n)
        !changeRead && changeFlags[FIFO_LIMIT_BIT]
        |=> changeFlags[FIFO_LIMIT_BIT]) // RULE5
        else $error("fifo flag dropped without read");

    AST_DRV_STICKY: assert property (@(posedge mclk) disable iff (!reset_n)
        !changeRead && changeFlags[DRIVE_MON_BIT]
        |=> changeFlags[DRIVE_MON_BIT]) // RULE4
        else $error("drive flag dropped without read");

    // A flag never rises without a change of its line
    AST_QRSS_NOSPUR: assert property (@(posedge mclk) disable iff (!reset_n)
        !$changed(status_ff[QRSS_BIT]) && !changeFlags[QRSS_BIT]
        |=> !changeFlags[QRSS_BIT]) // RULE6
        else $error("lock flag rose without change");

    AST_FIFO_NOSPUR: assert property (@(posedge mclk) disable iff (!reset_n)
        !$changed(status_ff[FIFO_LIMIT_BIT]) && !changeFlags[FIFO_LIMIT_BIT]
        |=> !changeFlags[FIFO_LIMIT_BIT]) // RULE6
        else $error("fifo flag rose without change");

    AST_DRV_NOSPUR: assert property (@(posedge mclk) disable iff (!reset_n)
        !$changed(status_ff[DRIVE_MON_BIT]) && !changeFlags[DRIVE_MON_BIT]
        |=> !changeFlags[DRIVE_MON_BIT]) // RULE6
        else $error("drive flag rose without change");

    // Interrupt level follows flag, enable and mask
    AST_IRQ_RAISE: assert property (@(posedge mclk) disable iff (!reset_n)
        |(changeFlags & enable_ff & mask_ff) |=> irq) // RULE2
        else $error("enabled flag gave no interrupt");

    AST_IRQ_NO_ENA: assert property (@(posedge mclk) disable iff (!reset_n)
        enable_ff == READ_ZERO |=> !irq) // RULE2
        else $error("interrupt with all enables off");

    AST_IRQ_NO_MASK: assert property (@(posedge mclk) disable iff (!reset_n)
        mask_ff == READ_ZERO |=> !irq) // RULE2
        else $error("interrupt with all mask bits off");

    // Enable and mask take writes only at their own address
    AST_ENA_WR_QRSS: assert property (@(posedge mclk) disable iff (!reset_n)
        regWr && sel == LSC_SEL_ENABLE
        |=> enable_ff[QRSS_BIT] == $past(regWdata[QRSS_BIT])) // RULE2
        else $error("lock enable write lost");

    AST_ENA_WR_FIFO: assert property (@(posedge mclk) disable iff (!reset_n)
        regWr && sel == LSC_SEL_ENABLE
        |=> enable_ff[FIFO_LIMIT_BIT] == $past(regWdata[FIFO_LIMIT_BIT]))
        else $error("fifo enable write lost"); // RULE5

    AST_ENA_WR_DRV: assert property (@(posedge mclk) disable iff (!reset_n)
        regWr && sel == LSC_SEL_ENABLE
        |=> enable_ff[DRIVE_MON_BIT] == $past(regWdata[DRIVE_MON_BIT]))
        else $error("drive enable write lost"); // RULE4

    AST_ENA_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        !(regWr && sel == LSC_SEL_ENABLE) |=> $stable(enable_ff)) // RULE2
        else $error("enable changed without write");

    AST_MASK_WR: assert property (@(posedge mclk) disable iff (!reset_n)
        regWr && sel == LSC_SEL_MASK
        |=> mask_ff[QRSS_BIT] == $past(regWdata[QRSS_BIT])) // RULE2
        else $error("lock mask write lost");

    AST_MASK_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        !(regWr && sel == LSC_SEL_MASK) |=> $stable(mask_ff)) // RULE2
        else $error("mask changed without write");

    // Read data stands only after a strobe, unmapped reads give zero
    AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!reset_n)
        !regRd |=> regRdata == READ_ZERO) // RULE6
        else $error("read data without strobe");

    AST_UNMAPPED: assert property (@(posedge mclk) disable iff (!reset_n)
        regRd && sel == LSC_SEL_NONE |=> regRdata == READ_ZERO) // RULE6
        else $error("unmapped read not zero");
endmodule

/* File: sim/lsc_irq_top_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        nChecks++; \
        if ((got) !== (ex)) begin \
            errorCnt++; \
            $display("wrong value %s exp %h got %h", nm, ex, got); \
        end \
    end
module lsc_irq_top_tb
    import lscirq_pkg::*;
;
    logic mclk;
    logic reset_n;
    logic qrssLockIn;
    logic driveMonitorIn;
    logic fifoLimitIn;
    logic [15:0] regAddr;
    logic [7:0] regWdata;
    logic regWr;
    logic regRd;
    logic [7:0] regRdata;
    logic irq;
    logic [7:0] rdv;
    logic [7:0] bitv [3] = '{8'h01, 8'h20, 8'h40};
    int errorCnt = 0;
    int nChecks = 0;
    int cycleCnt = 0;

    lsc_irq_top u_lsc_irq_top (
        .mclk(mclk),
        .reset_n(reset_n),
        .qrssLockIn(qrssLockIn),
        .driveMonitorIn(driveMonitorIn),
        .fifoLimitIn(fifoLimitIn),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWr(regWr),
        .regRd(regRd),
        .regRdata(regRdata),
        .irq(irq)
    );

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Verdict in one place, also reached by the hang guard
    task automatic summarize();
        $display("checks %0d errors %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Run takes well under a thousand cycles
    always @(posedge mclk) begin
        cycleCnt++;
        if (cycleCnt == 3000) begin
            errorCnt++;
            summarize();
        end
    end

    // One-cycle write strobe
    task automatic wrReg(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdReg(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic chkReg(input string nm, input logic [15:0] a,
            input logic [7:0] ex);
        logic [7:0] d;
        rdReg(a, d);
        `CHK(nm, ex, d)
    endtask

    // Bit 0 qrss, 1 fifo limit, 2 drive monitor; irq lands 3 edges later
    task automatic setIn(input logic [2:0] v);
        @(posedge mclk);
        qrssLockIn <= v[0];
        fifoLimitIn <= v[1];
        driveMonitorIn <= v[2];
        repeat (3) @(posedge mclk);
        #1;
    endtask

    initial begin
        reset_n = 1'b0;
        {qrssLockIn, driveMonitorIn, fifoLimitIn} = 3'b000;
        {regAddr, regWdata, regWr, regRd} = '0;
        // Line interface and framer taken as single-rail from here
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        `CHK("irq", 1'b0, irq)
        chkReg("status", ADDR_STATUS, STATUS_RESET);
        chkReg("change", ADDR_CHANGE_STATUS, CHANGE_RESET);
        chkReg("enable", ADDR_IRQ_ENABLE, ENABLE_RESET);
        chkReg("mask", ADDR_IRQ_MASK, MASK_RESET);
        wrReg(ADDR_IRQ_ENABLE, 8'hff);
        chkReg("enable", ADDR_IRQ_ENABLE, 8'h61);
        wrReg(ADDR_IRQ_MASK, 8'hff);
        chkReg("mask", ADDR_IRQ_MASK, 8'h61);
        wrReg(ADDR_STATUS, 8'hff);
        chkReg("status", ADDR_STATUS, 8'h00);
        wrReg(ADDR_CHANGE_STATUS, 8'hff);
        chkReg("change", ADDR_CHANGE_STATUS, READ_ZERO);
        chkReg("unmapped", 16'h0f07, READ_ZERO);
        // Each watched line: rise then fall, flag sticky until read
        for (int i = 0; i < 3; i++) begin
            setIn(3'b001 << i);
            `CHK("irq", 1'b1, irq)
            chkReg("status", ADDR_STATUS, bitv[i]);
            chkReg("change", ADDR_CHANGE_STATUS, bitv[i]);
            chkReg("change", ADDR_CHANGE_STATUS, 8'h00);
            `CHK("irq", 1'b0, irq)
            setIn(3'b000);
            `CHK("irq", 1'b1, irq)
            chkReg("change", ADDR_CHANGE_STATUS, bitv[i]);
        end
        // Disabled source still flags but stays quiet
        wrReg(ADDR_IRQ_ENABLE, 8'h00);
        setIn(3'b001);
        `CHK("irq", 1'b0, irq)
        chkReg("change", ADDR_CHANGE_STATUS, 8'h01);
        setIn(3'b111);
        chkReg("status", ADDR_STATUS, 8'h61);
        chkReg("change", ADDR_CHANGE_STATUS, 8'h60);
        // Change lands on the same edge as the clearing read
        @(posedge mclk);
        qrssLockIn <= 1'b0;
        rdReg(ADDR_CHANGE_STATUS, rdv);
        `CHK("change", 8'h00, rdv)
        repeat (2) @(posedge mclk);
        chkReg("change", ADDR_CHANGE_STATUS, 8'h01);
        chkReg("change", ADDR_CHANGE_STATUS, 8'h00);
        summarize();
    end
endmodule
